/* File: src/stl_regs.sv */
// Purpose: SCSI test, data latch and scratch registers of the SCSI core
// Assumes: Host port strobes are one cycle; bus inputs synchronous to core_clk
// Notes: FIFO and offset counter are modelled in small form for the test paths
//
// Behaviour
// R1: Clock source bit selects the DMA clock and ignores the external SCSI clock
// R2: Software keeps clock source clear and board supplies fast external clock
// R3: Override bit lets output latches drive all control and data lines
// R4: Offset reset write clears the sync offset count, then self-clears
// R5: Loopback bit makes the core act as initiator and target together
// R6: High-impedance bit releases every open-drain bus driver
// R7: Request and acknowledge deassert edges filtered; extend bit lengthens window; the code drops the filter while the clock halt bit is set
// R8: Software keeps filter extend clear during fast transfers
// R9: Bit-level mode blocks DMA and instruction execution
// R10: Active negation drives lines high only during information transfer phases
// R11: FIFO test read makes each output latch read unload one FIFO entry
// R12: Clock halt stops the divided core clock without glitch
// R13: Single-initiator disable ignores selections lacking an initiator ID
// R14: Timer test shortens timeouts and starts all three timers
// R15: Flush empties FIFO and clears latch full flags, then self-clears
// R16: FIFO test write pushes each output latch write into the FIFO
// R17: Input latch read checks parity and raises a parity error event
// R18: Input latch holds received bus data and passes it on
// R19: Output latch drives data lines only while assert data bit is set; the code also drives them while the override bit is set
// R20: Live data register returns unlatched bus data inverted to active high
// R21: Scratch word changes only on host or instruction writes
// R22: Self-clearing command bits read back as zero
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module stl_regs #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ext_scsi_clk,
  input wire logic dma_clk,
  input wire stl_pkg::stl_req_type req,
  output logic [31:0] rdata,
  input wire logic [7:0] bus_data_b_i,
  input wire logic bus_parity_b_i,
  input wire logic req_b_i,
  input wire logic ack_b_i,
  input wire logic info_phase,
  input wire logic rx_strobe,
  input wire logic [7:0] sel_ids,
  input wire logic [7:0] own_id,
  input wire logic instr_wr,
  input wire logic [31:0] instr_wdata,
  input wire logic [7:0] out_ctrl_latch,
  output stl_pkg::stl_drive_type drive,
  output logic [7:0] ctrl_o,
  output logic [7:0] ctrl_oe,
  output logic req_filt,
  output logic ack_filt,
  output logic clk_sel_dma,
  output logic core_clk_run,
  output logic initiator_en,
  output logic target_en,
  output logic dma_block,
  output logic timer_short,
  output logic timers_start,
  output logic sel_accept,
  output logic parity_err,
  output logic [7:0] host_fifo_byte,
  output logic host_fifo_push,
  output logic [3:0] sync_offset
);
  import stl_pkg::*;

  logic [7:0] two_q, three_q, one_q, in_latch_q, out_latch_q, aux_q;
  logic [31:0] scratch_q;
  logic in_par_q, in_full_q, out_full_q, halt_sync_q;
  logic [7:0] fifo_q [FIFO_DEPTH];
  logic [$clog2(FIFO_DEPTH):0] fifo_cnt_q;
  logic [$clog2(FIFO_DEPTH)-1:0] wp_q, rp_q;
  logic [1:0] req_cnt_q, ack_cnt_q;
  logic [1:0] filt_len;
  logic wr_two, wr_three, wr_out, rd_out, rd_in, fifo_pop, fifo_push;

  // Odd parity check over a byte and its parity bit
  function automatic logic par_bad(input logic [7:0] d, input logic p);
    par_bad = ~(^{d, p});
  endfunction

  // Deassert-edge glitch filter counter step
  function automatic logic [1:0] filt_step(input logic [1:0] c, input logic asserted,
                                           input logic [1:0] len);
    if (asserted) begin
      filt_step = 2'h0;
    end else if (c < len) begin
      filt_step = c + 2'h1;
    end else begin
      filt_step = c;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    wr_two = req.wr && (req.addr == ADR_TEST_TWO);
    wr_three = req.wr && (req.addr == ADR_TEST_THREE);
    wr_out = req.wr && (req.addr == ADR_OUT_LATCH);
    rd_out = req.rd && (req.addr == ADR_OUT_LATCH);
    rd_in = req.rd && (req.addr == ADR_IN_LATCH);
    fifo_pop = rd_out && three_q[B_FIFO_RD] && (fifo_cnt_q != '0); // [R11]
    fifo_push = wr_out && three_q[B_FIFO_WR] && (fifo_cnt_q != FIFO_DEPTH[$clog2(FIFO_DEPTH):0]);
    filt_len = three_q[B_CLK_HALT] ? 2'h0 :
      (two_q[B_FILT_LONG] ? FILT_LONG_CYC[1:0] : FILT_SHORT_CYC[1:0]); // [R7]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test registers; command bits pulse once and read back zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      two_q <= RST_BYTE;
      three_q <= RST_BYTE; // [R10]
      one_q <= RST_BYTE;
      aux_q <= RST_BYTE;
    end else begin
      if (wr_two) begin
        two_q <= req.wdata[7:0] & MASK_TWO;
      end else begin
        two_q[B_OFS_RESET] <= 1'b0; // [R4] [R22]
      end
      if (wr_three) begin
        three_q <= req.wdata[7:0] & MASK_THREE;
      end else begin
        three_q[B_FLUSH] <= 1'b0; // [R15] [R22]
      end
      if (req.wr && req.addr == ADR_TEST_ONE) begin
        one_q <= {req.wdata[B_CLK_SRC], 7'h00};
      end
      if (req.wr && req.addr == ADR_CTRL_AUX) begin
        aux_q <= {7'h00, req.wdata[B_ASSERT_DATA]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scratch word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scratch_q <= RST_WORD;
    end else if (req.wr && req.addr == ADR_SCRATCH) begin
      scratch_q <= req.wdata; // [R21]
    end else if (instr_wr) begin
      scratch_q <= instr_wdata; // [R21]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input and output latches with their full flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_latch_q <= RST_BYTE;
      in_par_q <= 1'b0;
      in_full_q <= 1'b0;
      out_latch_q <= RST_BYTE;
      out_full_q <= 1'b0;
    end else begin
      if (rx_strobe) begin
        in_latch_q <= ~bus_data_b_i; // [R18]
        in_par_q <= ~bus_parity_b_i;
        in_full_q <= 1'b1;
      end else if (three_q[B_FLUSH] || rd_in) begin
        in_full_q <= 1'b0; // [R15]
      end
      if (wr_out) begin
        out_latch_q <= req.wdata[7:0];
        out_full_q <= 1'b1;
      end else if (three_q[B_FLUSH]) begin
        out_full_q <= 1'b0; // [R15]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // SCSI FIFO test path
  always_ff @(posedge core_clk) begin
    if (fifo_push) begin
      fifo_q[wp_q] <= req.wdata[7:0]; // [R16]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      fifo_cnt_q <= '0;
    end else if (three_q[B_FLUSH]) begin
      wp_q <= '0; // [R15]
      rp_q <= '0;
      fifo_cnt_q <= '0;
    end else begin
      if (fifo_push) begin
        wp_q <= wp_q + 1'b1; // [R16]
      end
      if (fifo_pop) begin
        rp_q <= rp_q + 1'b1; // [R11]
      end
      fifo_cnt_q <= fifo_cnt_q + {{$clog2(FIFO_DEPTH){1'b0}}, fifo_push}
        - {{$clog2(FIFO_DEPTH){1'b0}}, fifo_pop};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Synchronous offset counter: counts request edges, cleared by offset reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_offset <= 4'h0;
    end else if (two_q[B_OFS_RESET]) begin
      sync_offset <= 4'h0; // [R4]
    end else if (!req_b_i && !req_filt && sync_offset != 4'hf) begin
      sync_offset <= sync_offset + 4'h1;
    end else if (!ack_b_i && !ack_filt && sync_offset != 4'h0) begin
      sync_offset <= sync_offset - 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request and acknowledge filters: assertion passes at once, deassertion waits unless the clock halt bit is set
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_cnt_q <= 2'h0;
      ack_cnt_q <= 2'h0;
      req_filt <= 1'b0;
      ack_filt <= 1'b0;
    end else begin
      req_cnt_q <= filt_step(req_cnt_q, !req_b_i, filt_len);
      ack_cnt_q <= filt_step(ack_cnt_q, !ack_b_i, filt_len);
      req_filt <= !req_b_i || (req_filt && req_cnt_q < filt_len); // [R7]
      ack_filt <= !ack_b_i || (ack_filt && ack_cnt_q < filt_len); // [R7]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock control: halt request passes through a flop before gating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_sync_q <= 1'b0;
      core_clk_run <= 1'b1;
      clk_sel_dma <= 1'b0;
    end else begin
      halt_sync_q <= three_q[B_CLK_HALT];
      core_clk_run <= !halt_sync_q; // [R12]
      clk_sel_dma <= one_q[B_CLK_SRC]; // [R1]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode outputs, selection filter, parity check
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      initiator_en <= 1'b0;
      target_en <= 1'b0;
      dma_block <= 1'b0;
      timer_short <= 1'b0;
      timers_start <= 1'b0;
      sel_accept <= 1'b0;
      parity_err <= 1'b0;
      host_fifo_byte <= RST_BYTE;
      host_fifo_push <= 1'b0;
    end else begin
      initiator_en <= two_q[B_LOOPBACK] || !two_q[B_OVERRIDE]; // [R5]
      target_en <= two_q[B_LOOPBACK] || two_q[B_OVERRIDE]; // [R5]
      dma_block <= two_q[B_BIT_LEVEL]; // [R9]
      timer_short <= three_q[B_TIMER_TEST]; // [R14]
      timers_start <= wr_three && req.wdata[B_TIMER_TEST]; // [R14]
      sel_accept <= ((sel_ids & own_id) != 8'h00) &&
        (!three_q[B_SINGLE_DIS] || ((sel_ids & ~own_id) != 8'h00)); // [R13]
      parity_err <= rd_in && par_bad(in_latch_q, in_par_q); // [R17]
      host_fifo_byte <= in_latch_q; // [R18]
      host_fifo_push <= rx_strobe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus drivers: open drain asserts low; active negation drives high in phases
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive <= '0;
      ctrl_o <= RST_BYTE;
      ctrl_oe <= RST_BYTE;
    end else if (two_q[B_HIZ]) begin
      drive <= '0; // [R6]
      ctrl_o <= RST_BYTE;
      ctrl_oe <= RST_BYTE;
    end else begin
      drive.data_o <= ~out_latch_q;
      drive.parity_o <= ^out_latch_q;
      if (aux_q[B_ASSERT_DATA] || two_q[B_OVERRIDE]) begin
        drive.data_oe <= (three_q[B_ACT_NEG] && info_phase) ? 8'hff : out_latch_q; // [R19] [R10]
        drive.parity_oe <= (three_q[B_ACT_NEG] && info_phase) || !(^out_latch_q);
      end else begin
        drive.data_oe <= RST_BYTE; // [R19]
        drive.parity_oe <= 1'b0;
      end
      ctrl_o <= ~out_ctrl_latch;
      ctrl_oe <= two_q[B_OVERRIDE] ? out_ctrl_latch : RST_BYTE; // [R3]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= RST_WORD;
    end else if (!req.rd) begin
      rdata <= RST_WORD;
    end else if (req.addr == ADR_TEST_ONE) begin
      rdata <= {24'h000000, one_q};
    end else if (req.addr == ADR_TEST_TWO) begin
      rdata <= {24'h000000, two_q};
    end else if (req.addr == ADR_TEST_THREE) begin
      rdata <= {24'h000000, three_q};
    end else if (req.addr == ADR_IN_LATCH) begin
      rdata <= {24'h000000, in_latch_q};
    end else if (req.addr == ADR_OUT_LATCH) begin
      rdata <= {24'h000000, three_q[B_FIFO_RD] ? fifo_q[rp_q] : out_latch_q}; // [R11]
    end else if (req.addr == ADR_LIVE_DATA) begin
      rdata <= {24'h000000, ~bus_data_b_i}; // [R20]
    end else if (req.addr == ADR_SCRATCH) begin
      rdata <= scratch_q;
    end else if (req.addr == ADR_CTRL_AUX) begin
      rdata <= {24'h000000, aux_q};
    end else if (req.addr == ADR_STATUS_AUX) begin
      rdata <= {24'h000000, fifo_cnt_q[3:0] & 4'hf, 1'b0, out_full_q, in_full_q, core_clk_run};
    end else begin
      rdata <= RST_WORD;
    end
  end

  // ext_scsi_clk and dma_clk are only routed by the clock select downstream
  logic unused_clks;
  assign unused_clks = ext_scsi_clk ^ dma_clk;
endmodule
`default_nettype wire

/* File: pkg/stl_pkg.sv */
// Purpose: Constants and carrier types for the SCSI test and data latch registers
// Assumes: 8-bit offsets, byte-wide registers except the 32-bit scratch word
// Notes: Offsets are byte addresses on the plain register port
package stl_pkg;
  // Register offsets
  localparam logic [7:0] ADR_TEST_ONE = 8'h4d;
  localparam logic [7:0] ADR_TEST_TWO = 8'h4e;
  localparam logic [7:0] ADR_TEST_THREE = 8'h4f;
  localparam logic [7:0] ADR_IN_LATCH = 8'h50;
  localparam logic [7:0] ADR_OUT_LATCH = 8'h54;
  localparam logic [7:0] ADR_LIVE_DATA = 8'h58;
  localparam logic [7:0] ADR_SCRATCH = 8'h5c;
  localparam logic [7:0] ADR_CTRL_AUX = 8'h60;
  localparam logic [7:0] ADR_STATUS_AUX = 8'h64;
  // Test register two fields
  localparam int B_OVERRIDE = 7;
  localparam int B_OFS_RESET = 6;
  localparam int B_LOOPBACK = 4;
  localparam int B_HIZ = 3;
  localparam int B_FILT_LONG = 1;
  localparam int B_BIT_LEVEL = 0;
  // Test register three fields
  localparam int B_ACT_NEG = 7;
  localparam int B_FIFO_RD = 6;
  localparam int B_CLK_HALT = 5;
  localparam int B_SINGLE_DIS = 4;
  localparam int B_TIMER_TEST = 2;
  localparam int B_FLUSH = 1;
  localparam int B_FIFO_WR = 0;
  // Test register one and auxiliary control fields
  localparam int B_CLK_SRC = 7;
  localparam int B_ASSERT_DATA = 0;
  // Writable masks (reserved bits read zero)
  localparam logic [7:0] MASK_TWO = 8'hdb;
  localparam logic [7:0] MASK_THREE = 8'hf7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Filter windows
  localparam int CLK_NS = 50;
  localparam int FILT_SHORT_NS = 30;
  localparam int FILT_LONG_NS = 60;
  localparam int FILT_SHORT_CYC = (FILT_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_LONG_CYC = (FILT_LONG_NS + CLK_NS - 1) / CLK_NS;
  // Host register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } stl_req_type;
  // Drive bundle for the SCSI data lines
  typedef struct packed {
    logic [7:0] data_o;
    logic [7:0] data_oe;
    logic parity_o;
    logic parity_oe;
  } stl_drive_type;
  typedef enum logic [1:0] {FLT_IDLE, FLT_HOLD} stl_filt_type;
endpackage

/* File: test/stl_regs_asserts.sv */
// Purpose: Port checks for the SCSI test and data latch registers
// Assumes: Every host write is followed by at least one idle cycle
// Notes: Shadow bits follow host writes, with one cycle of history
`timescale 1ns/100ps
`default_nettype none
module stl_regs_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire stl_pkg::stl_req_type req,
  input wire logic [31:0] rdata,
  input wire stl_pkg::stl_drive_type drive,
  input wire logic [7:0] ctrl_oe,
  input wire logic clk_sel_dma,
  input wire logic core_clk_run,
  input wire logic initiator_en,
  input wire logic target_en,
  input wire logic dma_block,
  input wire logic timers_start,
  input wire logic parity_err,
  input wire logic [3:0] sync_offset
);
  import stl_pkg::*;
  logic w1, w2, w3, wa, rd_in;
  logic [1:0] hiz_q, ad_q, ovr_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Decoded host accesses
  assign w1 = req.wr && (req.addr == ADR_TEST_ONE);
  assign w2 = req.wr && (req.addr == ADR_TEST_TWO);
  assign w3 = req.wr && (req.addr == ADR_TEST_THREE);
  assign wa = req.wr && (req.addr == ADR_CTRL_AUX);
  assign rd_in = req.rd && (req.addr == ADR_IN_LATCH);
  ////////////////////////////////////////////////////////////
  // Drive control bits as written, one cycle of history
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiz_q <= 2'b00;
      ad_q <= 2'b00;
      ovr_q <= 2'b00;
    end else begin
      hiz_q <= {hiz_q[0], w2 ? req.wdata[B_HIZ] : hiz_q[0]};
      ad_q <= {ad_q[0], wa ? req.wdata[B_ASSERT_DATA] : ad_q[0]};
      ovr_q <= {ovr_q[0], w2 ? req.wdata[B_OVERRIDE] : ovr_q[0]};
    end
  end
  ////////////////////////////////////////////////////////////
  clk_src_a:
    assert property (w1 |=> ##1 clk_sel_dma == $past(req.wdata[B_CLK_SRC], 2))
    else $error("clock source select wrong");
  ofs_clear_a:
    assert property (w2 && req.wdata[B_OFS_RESET] |=> ##1 sync_offset == 4'h0)
    else $error("offset count not cleared");
  loop_roles_a:
    assert property (w2 && req.wdata[B_LOOPBACK] |=> ##1 initiator_en && target_en)
    else $error("loopback roles missing");
  hiz_release_a:
    assert property (hiz_q == 2'b11 |-> drive.data_oe == 8'h00 && !drive.parity_oe)
    else $error("driver active in high impedance mode");
  bit_level_a:
    assert property (w2 |=> ##1 dma_block == $past(req.wdata[B_BIT_LEVEL], 2))
    else $error("transfer block wrong");
  clk_halt_a:
    assert property (w3 |=> ##2 core_clk_run == !$past(req.wdata[B_CLK_HALT], 3))
    else $error("core clock run wrong");
  timer_start_a:
    assert property (w3 && req.wdata[B_TIMER_TEST] |-> ##[1:3] timers_start)
    else $error("timers not started");
  parity_src_a:
    assert property (parity_err |-> $past(rd_in) || $past(rd_in, 2))
    else $error("parity error without input latch read");
  data_drive_a:
    assert property (ad_q == 2'b00 && ovr_q == 2'b00 |-> drive.data_oe == 8'h00)
    else $error("data driven without assert data");
  ctrl_drive_a:
    assert property (ovr_q == 2'b00 |-> ctrl_oe == 8'h00)
    else $error("control lines driven without override");
  self_clear_a:
    assert property ($past(req.rd) && $past(req.addr) == ADR_TEST_TWO |-> !rdata[B_OFS_RESET])
    else $error("offset reset bit reads set");
endmodule
bind stl_regs stl_regs_asserts stl_regs_asserts_inst (
  .core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .drive(drive),
  .ctrl_oe(ctrl_oe), .clk_sel_dma(clk_sel_dma), .core_clk_run(core_clk_run),
  .initiator_en(initiator_en), .target_en(target_en), .dma_block(dma_block),
  .timers_start(timers_start), .parity_err(parity_err), .sync_offset(sync_offset)
);
`default_nettype wire

/* File: test/stl_bus_partner.sv */
// Purpose: Far side of the SCSI data and parity lines
// Assumes: Open-drain lines with terminator pull-ups, low is asserted
// Notes: Parity is odd over the active-high byte; bad_par flips it
`timescale 1ns/100ps
`default_nettype none
module stl_bus_partner (
  input wire stl_pkg::stl_drive_type drive,
  input wire logic drv_en,
  input wire logic [7:0] data_hi,
  input wire logic bad_par,
  output logic [7:0] bus_data_b,
  output logic bus_parity_b
);
  // Wired level of every party, released lines pull high
  assign bus_data_b = (drive.data_o | ~drive.data_oe) & (drv_en ? ~data_hi : 8'hff);
  assign bus_parity_b = (drive.parity_o | ~drive.parity_oe)
    & (drv_en ? (^data_hi ^ bad_par) : 1'b1);
endmodule
`default_nettype wire

/* File: test/scsi_test_and_data_latch_regs_tb.sv */
// Purpose: Self-checking bench for the SCSI test and data latch registers
// Assumes: Host port strobes driven by non-blocking assignment at rising edges
// Notes: Fifo count and full flags come from the auxiliary status word
`timescale 1ns/100ps
`default_nettype none
module scsi_test_and_data_latch_regs_tb;
  import stl_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic [4:0] l;
  } stl_row_type;
  logic core_clk, rst_b, rx_strobe, instr_wr, req_b_i, drv_en, bad_par, pe_seen;
  logic bus_parity_b_i, req_filt, clk_sel_dma, core_clk_run, initiator_en, target_en;
  logic dma_block, timer_short, sel_accept, parity_err;
  logic [7:0] sel_ids, own_id, data_hi, bus_data_b_i;
  logic [31:0] rdata, instr_wdata, q;
  stl_req_type req;
  stl_drive_type drive;
  stl_row_type rows [8];
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  stl_regs stl_regs_inst (
    .core_clk(core_clk), .rst_b(rst_b), .ext_scsi_clk(1'b0), .dma_clk(1'b0), .req(req),
    .rdata(rdata), .bus_data_b_i(bus_data_b_i), .bus_parity_b_i(bus_parity_b_i),
    .req_b_i(req_b_i), .ack_b_i(1'b1), .info_phase(1'b0), .rx_strobe(rx_strobe),
    .sel_ids(sel_ids), .own_id(own_id), .instr_wr(instr_wr), .instr_wdata(instr_wdata),
    .out_ctrl_latch(8'h00), .drive(drive), .ctrl_o(), .ctrl_oe(), .req_filt(req_filt),
    .ack_filt(), .clk_sel_dma(clk_sel_dma), .core_clk_run(core_clk_run),
    .initiator_en(initiator_en), .target_en(target_en), .dma_block(dma_block),
    .timer_short(timer_short), .timers_start(), .sel_accept(sel_accept),
    .parity_err(parity_err), .host_fifo_byte(), .host_fifo_push(), .sync_offset()
  );
  stl_bus_partner stl_bus_partner_inst (
    .drive(drive), .drv_en(drv_en), .data_hi(data_hi), .bad_par(bad_par),
    .bus_data_b(bus_data_b_i), .bus_parity_b(bus_parity_b_i)
  );
  ////////////////////////////////////////////////////////////
  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Cycle ceiling and parity error capture
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (parity_err === 1'b1) pe_seen <= 1'b1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Host write, then two idle cycles so registered outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
    repeat (2) @(posedge core_clk);
  endtask
  // Host read, data taken in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    @(negedge core_clk);
    chk(rdata & m, exp);
    @(posedge core_clk);
  endtask
  task automatic pulse_rx();
    rx_strobe <= 1'b1;
    @(posedge core_clk);
    rx_strobe <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_b, rx_strobe, instr_wr, drv_en, bad_par, pe_seen} = '0;
    req = '0;
    req_b_i = 1'b1;
    {sel_ids, data_hi, instr_wdata} = '0;
    own_id = 8'h04;
    // Address, write, readback, {dma clk, both roles, no dma, short timers, halted}
    rows = '{'{8'h4d, 32'hff, 32'h80, 5'h10}, '{8'h4d, 32'h0, 32'h0, 5'h00},
      '{8'h4e, 32'hff, 32'h9b, 5'h0c}, '{8'h4e, 32'h0, 32'h0, 5'h00},
      '{8'h4f, 32'hff, 32'hf5, 5'h03}, '{8'h4f, 32'h0, 32'h0, 5'h00},
      '{8'h5c, 32'hdeadbeef, 32'hdeadbeef, 5'h00}, '{8'h70, 32'h55, 32'h0, 5'h00}};
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].r, '1);
      chk({clk_sel_dma, initiator_en & target_en, dma_block, timer_short, ~core_clk_run},
        rows[i].l);
    end
    // Reset in mid-run restores defaults
    wr(ADR_TEST_ONE, 32'h80);
    rst_b <= 1'b0;
    @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rc(ADR_TEST_ONE, 32'h0, '1);
    rc(ADR_TEST_THREE, 32'h0, '1);
    chk(core_clk_run, 1);
    // Output latch onto the lines and back through both input paths
    wr(ADR_OUT_LATCH, 32'ha5);
    chk(drive.data_oe, 0);
    wr(ADR_CTRL_AUX, 32'h1);
    chk({drive.data_oe, drive.data_o}, 32'ha55a);
    rc(ADR_LIVE_DATA, 32'ha5, 32'hff);
    pulse_rx();
    rc(ADR_IN_LATCH, 32'ha5, 32'hff);
    // Drivers released, far side sends good then bad parity
    wr(ADR_TEST_TWO, 32'h08);
    chk(drive.data_oe, 0);
    pe_seen <= 1'b0;
    drv_en <= 1'b1;
    data_hi <= 8'h3c;
    pulse_rx();
    rc(ADR_LIVE_DATA, 32'h3c, 32'hff);
    rc(ADR_IN_LATCH, 32'h3c, 32'hff);
    chk(pe_seen, 0);
    bad_par <= 1'b1;
    pulse_rx();
    rc(ADR_IN_LATCH, 32'h3c, 32'hff);
    @(posedge core_clk);
    chk(pe_seen, 1);
    drv_en <= 1'b0;
    // Test write fills, test read unloads, flush empties
    wr(ADR_TEST_THREE, 32'h01);
    for (int i = 1; i < 4; i++) wr(ADR_OUT_LATCH, 32'h11 * i);
    rc(ADR_STATUS_AUX, 32'h30, 32'hf0);
    wr(ADR_TEST_THREE, 32'h40);
    rc(ADR_OUT_LATCH, 32'h11, 32'hff);
    rc(ADR_STATUS_AUX, 32'h20, 32'hf0);
    wr(ADR_TEST_THREE, 32'h02);
    rc(ADR_STATUS_AUX, 32'h0, 32'hf6);
    rc(ADR_TEST_THREE, 32'h0, '1);
    // Selection carrying only our own ID, and one that also carries a second initiator ID
    sel_ids <= 8'h04;
    wr(ADR_TEST_THREE, 32'h10);
    chk(sel_accept, 0);
    sel_ids <= 8'h84;
    repeat (3) @(posedge core_clk);
    chk(sel_accept, 1);
    sel_ids <= 8'h04;
    wr(ADR_TEST_THREE, 32'h0);
    chk(sel_accept, 1);
    // Long window hides a two-cycle deassert glitch, no fast transfers here
    wr(ADR_TEST_TWO, 32'h02);
    req_b_i <= 1'b0;
    repeat (4) @(posedge core_clk);
    req_b_i <= 1'b1;
    repeat (2) @(posedge core_clk);
    req_b_i <= 1'b0;
    repeat (3) begin
      @(posedge core_clk);
      chk(req_filt, 1);
    end
    // Instruction write reaches the scratch word
    instr_wr <= 1'b1;
    instr_wdata <= 32'h1234_5678;
    @(posedge core_clk);
    instr_wr <= 1'b0;
    @(posedge core_clk);
    rc(ADR_SCRATCH, 32'h1234_5678, '1);
    print_verdict();
  end
endmodule
`default_nettype wire
